// ### verilog/psr_pkg.sv
// Constants for the status and identifier register bank
// Contract
// - Status bit 15 reads zero; four-pair mode unsupported.
// - Status bits 14 and 13 read one; 100BASE-X full and half duplex.
// - Status bits 12 and 11 read one; 10BASE-T full and half duplex.
// - Status bits 10 and 9 read zero; two-pair mode unsupported.
// - Status bit 8 reads one; extended status lives in register 15. This bank does not decode register 15, so it reads zero.
// - Status bit 6 reads one; frames without preamble are accepted.
// - Status bit 5 shows negotiation complete; cleared by either reset.
// - Status bit 4 latches high on remote fault until read; resets zero.
// - Status bit 3 reads one; auto-negotiation ability present.
// - Status bit 2 latches low on link loss until read; resets zero.
// - Second read shows present link; real-time link bit also provided.
// - Status bit 1 latches high on jabber until read; resets zero.
// - Status bit 0 reads one; bit 7 reserved reads zero.
// - Identifier registers carry vendor identifier bits 3-18 and 19-24.
package psr_pkg;
	localparam logic [4:0]  ADDR_STATUS = 5'h01;
	localparam logic [4:0]  ADDR_ID_HI  = 5'h02;
	localparam logic [4:0]  ADDR_ID_LO  = 5'h03;
	localparam logic [4:0]  ADDR_IRQ_ST = 5'h10;
	localparam logic [4:0]  ADDR_IRQ_MK = 5'h11;
	// Fixed status bits: 14,13,12,11,8,6,3,0 set
	localparam logic [15:0] STATUS_FIXED = 16'h7949;
	localparam int BIT_ANEG   = 5;
	localparam int BIT_RFAULT = 4;
	localparam int BIT_LINK   = 2;
	localparam int BIT_JABBER = 1;
	// Arbitrary neutral identity values
	localparam logic [15:0] VENDOR_ID_HI  = 16'h0a5a;
	localparam logic [5:0]  VENDOR_ID_LOW = 6'h15;
	localparam logic [5:0]  MODEL_NUM     = 6'h01;
	localparam logic [3:0]  REVISION_NUM  = 4'h0;
	// Interrupt event bits
	localparam int IRQ_RFAULT = 0;
	localparam int IRQ_LINKDN = 1;
	localparam int IRQ_JABBER = 2;
	localparam int IRQ_ANEG   = 3;
	localparam logic [3:0]  IRQ_RESET = 4'h0;
endpackage

// ### verilog/psr_regs.sv
// Status, identifier and event registers of the copper PHY
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
module psr_regs (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        sw_reset,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        aneg_done,
	input  wire logic        remote_fault,
	input  wire logic        link_up,
	input  wire logic        jabber,
	output logic             link_real_time,
	output logic             irq
);
	logic        aneg_q;
	logic        rfault_q;
	logic        link_q;
	logic        jabber_q;
	logic [3:0]  irq_st_q;
	logic [3:0]  irq_mk_q;
	logic [3:0]  irq_ev;
	logic        link_prev_q;
	logic        rd_status;
	logic [15:0] status_word;
	logic [15:0] rdata_d;

	assign rd_status = reg_rd && (reg_addr == psr_pkg::ADDR_STATUS);

	always_comb begin
		status_word = psr_pkg::STATUS_FIXED;
		status_word[psr_pkg::BIT_ANEG]   = aneg_q;
		status_word[psr_pkg::BIT_RFAULT] = rfault_q;
		status_word[psr_pkg::BIT_LINK]   = link_q;
		status_word[psr_pkg::BIT_JABBER] = jabber_q;
	end

	// Negotiation state, cleared by either reset
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			aneg_q <= 1'b0;
		end else if (sw_reset) begin
			aneg_q <= 1'b0;
		end else begin
			aneg_q <= aneg_done;
		end
	end

	// Latch-high and latch-low bits; a read reloads from the live value
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rfault_q <= 1'b0;
			link_q   <= 1'b0;
			jabber_q <= 1'b0;
		end else if (sw_reset) begin
			rfault_q <= 1'b0;
			link_q   <= 1'b0;
			jabber_q <= 1'b0;
		end else if (rd_status) begin
			rfault_q <= remote_fault;
			link_q   <= link_up;
			jabber_q <= jabber;
		end else begin
			rfault_q <= rfault_q | remote_fault;
			link_q   <= link_q & link_up;
			jabber_q <= jabber_q | jabber;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			link_real_time <= 1'b0;
			link_prev_q    <= 1'b0;
		end else begin
			link_real_time <= link_up;
			link_prev_q    <= link_up;
		end
	end

	always_comb begin
		irq_ev = 4'h0;
		irq_ev[psr_pkg::IRQ_RFAULT] = remote_fault;
		irq_ev[psr_pkg::IRQ_LINKDN] = link_prev_q & ~link_up;
		irq_ev[psr_pkg::IRQ_JABBER] = jabber;
		irq_ev[psr_pkg::IRQ_ANEG]   = aneg_done & ~aneg_q;
	end

	// Sticky events, set wins over write-one-to-clear
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_st_q <= psr_pkg::IRQ_RESET;
		end else if (reg_wr && reg_addr == psr_pkg::ADDR_IRQ_ST) begin
			irq_st_q <= (irq_st_q & ~reg_wdata[3:0]) | irq_ev;
		end else begin
			irq_st_q <= irq_st_q | irq_ev;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_mk_q <= psr_pkg::IRQ_RESET;
		end else if (reg_wr && reg_addr == psr_pkg::ADDR_IRQ_MK) begin
			irq_mk_q <= reg_wdata[3:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_st_q & irq_mk_q);
		end
	end

	// Writes to status and identifiers have no effect
	always_comb begin
		rdata_d = 16'h0000;
		if (reg_rd) begin
			unique case (reg_addr)
				psr_pkg::ADDR_STATUS: rdata_d = status_word;
				psr_pkg::ADDR_ID_HI:  rdata_d = psr_pkg::VENDOR_ID_HI;
				psr_pkg::ADDR_ID_LO:  rdata_d = {psr_pkg::VENDOR_ID_LOW,
					psr_pkg::MODEL_NUM, psr_pkg::REVISION_NUM};
				psr_pkg::ADDR_IRQ_ST: rdata_d = {12'h000, irq_st_q};
				psr_pkg::ADDR_IRQ_MK: rdata_d = {12'h000, irq_mk_q};
				default:              rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= rdata_d;
		end
	end

	a_fixed_bits: assert property (@(posedge core_clk) disable iff (!rst_b)
		$past(rd_status) |-> (reg_rdata & 16'hffc9) == 16'h7949)
		else $error("fixed status bits wrong");
	a_rfault_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		(rfault_q && !rd_status && !sw_reset) |=> rfault_q)
		else $error("remote fault latch dropped");
	a_jabber_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		(jabber && !sw_reset) |=> jabber_q)
		else $error("jabber not latched");
	a_link_low: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!link_up && !sw_reset) |=> !link_q)
		else $error("link loss not latched");
	a_link_reload: assert property (@(posedge core_clk) disable iff (!rst_b)
		(rd_status && !sw_reset) |=> link_q == $past(link_up))
		else $error("link bit not reloaded on read");
	a_aneg_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		sw_reset |=> !aneg_q)
		else $error("negotiation bit not cleared");
	a_id_words: assert property (@(posedge core_clk) disable iff (!rst_b)
		(reg_rd && reg_addr == psr_pkg::ADDR_ID_LO) |=>
		reg_rdata[15:10] == psr_pkg::VENDOR_ID_LOW)
		else $error("identifier low wrong");
	a_model_rev: assert property (@(posedge core_clk) disable iff (!rst_b)
		(reg_rd && reg_addr == psr_pkg::ADDR_ID_LO) |=>
		reg_rdata[9:0] == {psr_pkg::MODEL_NUM, psr_pkg::REVISION_NUM})
		else $error("model or revision wrong");
	a_wr_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == psr_pkg::ADDR_STATUS && !sw_reset &&
		!remote_fault && !rfault_q) |=> !rfault_q)
		else $error("write changed status");
	c_rfault: cover property (@(posedge core_clk) rfault_q && rd_status);
	c_link_loss: cover property (@(posedge core_clk) link_prev_q && !link_up);
	c_irq: cover property (@(posedge core_clk) irq);
endmodule

// ### sim/psr_host.sv
// Management host model issuing register cycles
`timescale 1ns/1ns
module psr_host (
	input  wire logic        core_clk,
	input  wire logic [15:0] reg_rdata,
	output logic      [4:0]  reg_addr,
	output logic      [15:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd
);
	initial begin
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
endmodule

// ### sim/phy_status_and_id_registers_bench.sv
// Bench for the status and identifier register bank
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module phy_status_and_id_registers_bench;
	logic core_clk, rst_b, sw_reset, reg_wr, reg_rd, irq, lrt;
	logic aneg_done, remote_fault, link_up, jabber;
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	int fails = 0, n_tests = 0;
	psr_host host (.core_clk(core_clk), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd));
	psr_regs dut (.core_clk(core_clk), .rst_b(rst_b), .sw_reset(sw_reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .aneg_done(aneg_done),
		.remote_fault(remote_fault), .link_up(link_up), .jabber(jabber),
		.link_real_time(lrt), .irq(irq));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// Toggles one live input twice, one cycle apart
	task automatic pulse(input logic [1:0] sel);
		repeat (2) begin
			@(posedge core_clk);
			case (sel)
				2'd0: jabber <= ~jabber;
				2'd1: remote_fault <= ~remote_fault;
				2'd2: link_up <= ~link_up;
				default: sw_reset <= ~sw_reset;
			endcase
		end
		repeat (3) @(posedge core_clk);
	endtask
	task automatic t_fixed;
		host.wr(5'h01, 16'hffff);
		host.wr(5'h02, 16'h0000);
		host.rd(5'h01, d); `CHK("status", 16'h7949, d)
		host.rd(5'h02, d); `CHK("id_hi", psr_pkg::VENDOR_ID_HI, d)
		host.rd(5'h03, d); `CHK("id_lo", {psr_pkg::VENDOR_ID_LOW,
			psr_pkg::MODEL_NUM, psr_pkg::REVISION_NUM}, d)
		host.rd(5'h05, d); `CHK("unmapped", 16'h0000, d)
	endtask
	task automatic t_latch;
		host.wr(5'h10, 16'h000f);
		link_up <= 1'b1;
		pulse(2'd0);
		`CHK("lrt", 1'b1, lrt)
		`CHK("irq_masked", 1'b0, irq)
		host.rd(5'h01, d); `CHK("link_first", 16'h794b, d)
		host.rd(5'h01, d); `CHK("link_second", 16'h794d, d)
		pulse(2'd1);
		aneg_done <= 1'b1;
		host.rd(5'h01, d); `CHK("rfault", 16'h797d, d)
		host.rd(5'h01, d); `CHK("rf_cleared", 16'h796d, d)
		pulse(2'd2);
		host.wr(5'h11, 16'h0002);
		repeat (2) @(posedge core_clk);
		`CHK("irq_on", 1'b1, irq)
		host.rd(5'h01, d); `CHK("link_drop", 16'h7969, d)
		host.wr(5'h10, 16'h0002);
		repeat (2) @(posedge core_clk);
		`CHK("irq_off", 1'b0, irq)
	endtask
	task automatic t_swreset;
		aneg_done <= 1'b0;
		pulse(2'd3);
		host.rd(5'h01, d); `CHK("sw_reset", 16'h7949, d)
		host.rd(5'h01, d); `CHK("sw_relink", 16'h794d, d)
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		{sw_reset, aneg_done, remote_fault, link_up, jabber} = 5'h00;
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		t_fixed();
		t_latch();
		t_swreset();
		report_and_stop();
	end
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end
endmodule
